// ==== power_sequencer.sv ====
`timescale 1ns/100ps
// Behaviour
// - reference on only above rising UVLO
// - three regulators enabled together after reference
// - own 7-bit DAC, boost/gate-on ramp up
// - gate-off DAC ramps down in 128 steps
// - soft-start lasts about 14ms
// - delay pin grounded throughout soft-start
// - after regulation, release pin; threshold enables switch
// - delay pin grounded before startup and in UVLO
// - select ignored until all four conditions hold
// - select high: source switch on, drain off
// - select low: source switch off, drain on
// - steady state: low output starts fault timer
// - continuous 200ms fault latches, outputs off
// - fault latch cleared only by supply cycle
// - no low-output fault detection during soft-start
// - overtemperature latches fault at once
// - UVLO turns regulators, switch, op amps off
module power_sequencer #(
	parameter int unsigned FAULT_CYCLES = seq_pkg::FAULT_CYC,
	parameter int unsigned SS_STEP      = seq_pkg::SS_STEP_CYC
) (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire seq_pkg::sense_t sense,
	input  wire logic [3:0]      address,
	input  wire logic            read,
	input  wire logic            write,
	input  wire logic [31:0]     writedata,
	output logic      [31:0]     readdata,
	output logic                 waitrequest,
	output seq_pkg::rails_t      rails,
	output logic      [6:0]      boost_dac,
	output logic      [6:0]      gon_dac,
	output logic      [6:0]      goff_dac,
	output logic                 irq
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		seq_pkg::seq_state_t st;
		logic                supply_on;  // UVLO with hysteresis
		logic [22:0]         ftmr;       // Fault timer
		seq_pkg::rails_t     rails;
		logic [3:0]          irq_st;     // Sticky events
		logic [3:0]          irq_mask;
		logic                sw_en;      // Software switch gate
		logic                irq;
		logic                waitreq;
		logic [31:0]         rdata;
	} seq_regs_t;

	seq_regs_t       s_reg;
	seq_regs_t       s_next;
	seq_pkg::sense_t sn;        // Synchronised levels
	logic            all_ok;    // Every output above threshold
	logic            ss_done;   // All three ramps complete
	logic            det_en;    // Fault detection armed
	logic            expire;    // Fault timer at its end
	logic            take;      // Bus request accepted
	logic            commit;    // Bus request answered
	logic [3:0]      ev;        // Events this cycle
	logic [3:0]      w1c;       // Status bits cleared by software
	logic [2:0]      ss_dn;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Comparator outputs are asynchronous to clk; only the
	// two-stage synchronised copy reaches the sequencer
	level_sync #(
		.W ($bits(seq_pkg::sense_t))
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   (sense),
		.q   (sn)
	);

	// ------------------------------------------------------------
	// Soft-start DACs, one per regulator
	// ------------------------------------------------------------
	softstart_dac #(
		.DOWN     (1'b0),
		.STEP_CYC (SS_STEP)
	) u_boost (
		.clk  (clk),
		.rst  (rst),
		.run  (s_reg.rails.boost_en),
		.code (boost_dac),
		.done (ss_dn[0])
	);

	softstart_dac #(
		.DOWN     (1'b0),
		.STEP_CYC (SS_STEP)
	) u_gon (
		.clk  (clk),
		.rst  (rst),
		.run  (s_reg.rails.gon_en),
		.code (gon_dac),
		.done (ss_dn[1])
	);

	// Gate-off ramps from reference down to its low end point
	softstart_dac #(
		.DOWN     (1'b1),
		.STEP_CYC (SS_STEP)
	) u_goff (
		.clk  (clk),
		.rst  (rst),
		.run  (s_reg.rails.goff_en),
		.code (goff_dac),
		.done (ss_dn[2])
	);

	// ------------------------------------------------------------
	// Status word for reads
	// ------------------------------------------------------------
	function automatic logic [31:0] status_word(
		input seq_regs_t r,
		input logic      sel,
		input logic      ok
	);
		logic [31:0] w;
		w = '0;
		w[seq_pkg::STS_STATE +: 3] = r.st;
		w[seq_pkg::STS_FAULT]      = (r.st == seq_pkg::ST_FAULT);
		w[seq_pkg::STS_SUPP]       = r.supply_on;
		w[seq_pkg::STS_SEL]        = sel;
		w[seq_pkg::STS_OK]         = ok;
		return w;
	endfunction : status_word

	// ------------------------------------------------------------
	// Sequencer, fault timer, interrupts and bus slave
	// ------------------------------------------------------------
	always_comb
	begin
		s_next  = s_reg;
		all_ok  = sn.boost_ok && sn.gon_ok && sn.goff_ok;
		ss_done = &ss_dn;
		ev      = '0;
		w1c     = '0;
		take    = (read || write) && s_reg.waitreq;
		commit  = (read || write) && !s_reg.waitreq;

		// UVLO hysteresis: rise above one level, fall below other
		if (sn.supply_above_rise)
			s_next.supply_on = 1'b1;
		else if (!sn.supply_above_fall)
			s_next.supply_on = 1'b0;

		// Fault timer only counts once ramps are over
		det_en = (s_reg.st == seq_pkg::ST_REGW) ||
		         (s_reg.st == seq_pkg::ST_DELAY) ||
		         (s_reg.st == seq_pkg::ST_RUN);
		expire = det_en && !all_ok &&
		         (s_reg.ftmr == 23'(FAULT_CYCLES - 1));
		if (det_en && !all_ok)
			s_next.ftmr = s_reg.ftmr + 23'h000001;
		else
			s_next.ftmr = '0;  // Any good sample restarts the count

		// Main sequence
		case (s_reg.st)
			seq_pkg::ST_OFF:
				if (s_reg.supply_on)
					s_next.st = seq_pkg::ST_REF;
			seq_pkg::ST_REF:
				if (sn.ref_above_en)
					s_next.st = seq_pkg::ST_SOFT;
			seq_pkg::ST_SOFT:
				if (ss_done)
					s_next.st = seq_pkg::ST_REGW;
			seq_pkg::ST_REGW:
				if (all_ok)
					s_next.st = seq_pkg::ST_DELAY;
			seq_pkg::ST_DELAY:
				if (sn.cap_above)
					s_next.st = seq_pkg::ST_RUN;
			seq_pkg::ST_RUN:
				s_next.st = seq_pkg::ST_RUN;
			seq_pkg::ST_FAULT:
				s_next.st = seq_pkg::ST_FAULT;
			default:
				s_next.st = seq_pkg::ST_OFF;
		endcase

		// Timer expiry and heat both latch the fault
		if (s_reg.st != seq_pkg::ST_OFF &&
		    s_reg.st != seq_pkg::ST_FAULT)
		begin
			if (sn.over_temp)
			begin
				s_next.st      = seq_pkg::ST_FAULT;
				ev[seq_pkg::EV_THERM] = 1'b1;
			end
			else if (expire)
				s_next.st      = seq_pkg::ST_FAULT;
		end

		// Supply loss beats everything and is the only way out
		// of the fault latch
		if (!s_reg.supply_on)
			s_next.st = seq_pkg::ST_OFF;

		// Outputs follow the next state so they change with it
		s_next.rails.ref_en   = (s_next.st != seq_pkg::ST_OFF);
		s_next.rails.boost_en =
			(s_next.st inside {seq_pkg::ST_SOFT, seq_pkg::ST_REGW,
			 seq_pkg::ST_DELAY, seq_pkg::ST_RUN});
		s_next.rails.gon_en   = s_next.rails.boost_en;
		s_next.rails.goff_en  = s_next.rails.boost_en;
		// Pin released only while waiting on the capacitor or run
		s_next.rails.delay_cap_pin_low =
			!(s_next.st inside {seq_pkg::ST_DELAY,
			  seq_pkg::ST_RUN});
		s_next.rails.opamp_en = (s_next.st == seq_pkg::ST_RUN);
		// Select reaches the switches only in run
		if (s_next.st == seq_pkg::ST_RUN && s_reg.sw_en)
		begin
			s_next.rails.source_switch_on =
				sn.switch_select_input;
			s_next.rails.drain_switch_on  =
				!sn.switch_select_input;
		end
		else
		begin
			s_next.rails.source_switch_on = 1'b0;
			s_next.rails.drain_switch_on  = 1'b0;
		end

		// Events
		if (s_next.st == seq_pkg::ST_RUN &&
		    s_reg.st != seq_pkg::ST_RUN)
			ev[seq_pkg::EV_RUN] = 1'b1;
		if (s_next.st == seq_pkg::ST_FAULT &&
		    s_reg.st != seq_pkg::ST_FAULT)
			ev[seq_pkg::EV_FAULT] = 1'b1;
		if (s_reg.supply_on && !s_next.supply_on)
			ev[seq_pkg::EV_UVLO] = 1'b1;

		// Bus: one wait cycle, answer on the next edge
		s_next.waitreq = !take;
		if (take && read)
		begin
			case (address)
				seq_pkg::OFS_STATUS:
					s_next.rdata = status_word(s_reg,
						sn.switch_select_input, all_ok);
				seq_pkg::OFS_IRQ_STAT:
					s_next.rdata = {28'h0000000, s_reg.irq_st};
				seq_pkg::OFS_IRQ_MASK:
					s_next.rdata = {28'h0000000, s_reg.irq_mask};
				seq_pkg::OFS_CTRL:
					s_next.rdata = {31'h00000000, s_reg.sw_en};
				default:
					s_next.rdata = '0;  // Unmapped reads zero
			endcase
		end
		if (commit && write)
		begin
			case (address)
				seq_pkg::OFS_IRQ_STAT:
					w1c = writedata[3:0];
				seq_pkg::OFS_IRQ_MASK:
					s_next.irq_mask = writedata[3:0];
				seq_pkg::OFS_CTRL:
					s_next.sw_en = writedata[0];
				default:
					s_next.sw_en = s_reg.sw_en;  // Ignored
			endcase
		end

		// A new event wins over a clear in the same cycle
		s_next.irq_st = (s_reg.irq_st & ~w1c) | ev;
		s_next.irq    = |(s_next.irq_st & s_next.irq_mask);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_reg          <= '0;
			s_reg.st       <= seq_pkg::ST_OFF;
			s_reg.rails.delay_cap_pin_low <= 1'b1;
			s_reg.irq_mask <= seq_pkg::MASK_RST;
			s_reg.sw_en    <= seq_pkg::SW_EN_RST;
			s_reg.waitreq  <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	assign rails       = s_reg.rails;
	assign irq         = s_reg.irq;
	assign waitrequest = s_reg.waitreq;
	assign readdata    = s_reg.rdata;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	ref_gate_a: assert property (!s_reg.supply_on |=>
		!rails.ref_en)
		else $error("reference on below UVLO");
	regs_together_a: assert property ($rose(rails.boost_en) |->
		rails.gon_en && rails.goff_en && rails.ref_en)
		else $error("regulators not enabled together");
	pin_soft_a: assert property (rails.boost_en && !ss_done |->
		rails.delay_cap_pin_low)
		else $error("delay pin released during soft-start");
	pin_release_a: assert property (s_reg.st ==
		seq_pkg::ST_DELAY && sn.cap_above && !sn.over_temp &&
		s_reg.supply_on && all_ok |=> rails.opamp_en)
		else $error("op amps not enabled after delay");
	pin_uvlo_a: assert property (!s_reg.supply_on |=>
		rails.delay_cap_pin_low)
		else $error("delay pin released in UVLO");
	sel_gate_a: assert property (!rails.opamp_en |->
		!rails.source_switch_on && !rails.drain_switch_on)
		else $error("switch moved before activation");
	sel_high_a: assert property (s_next.st == seq_pkg::ST_RUN &&
		s_reg.sw_en && sn.switch_select_input |=>
		rails.source_switch_on && !rails.drain_switch_on)
		else $error("select high not followed");
	sel_low_a: assert property (s_next.st == seq_pkg::ST_RUN &&
		s_reg.sw_en && !sn.switch_select_input |=>
		!rails.source_switch_on && rails.drain_switch_on)
		else $error("select low not followed");
	timer_run_a: assert property (det_en && !all_ok &&
		s_reg.supply_on && s_next.st != seq_pkg::ST_FAULT |=>
		s_reg.ftmr == $past(s_reg.ftmr) + 23'h000001)
		else $error("fault timer not counting");
	fault_time_a: assert property (expire && s_reg.supply_on |=>
		s_reg.st == seq_pkg::ST_FAULT && !rails.boost_en &&
		rails.ref_en)
		else $error("fault latch missed at timer end");
	fault_hold_a: assert property (s_reg.st ==
		seq_pkg::ST_FAULT && s_reg.supply_on |=>
		s_reg.st == seq_pkg::ST_FAULT)
		else $error("fault latch left without supply cycle");
	soft_nodet_a: assert property (s_reg.st ==
		seq_pkg::ST_SOFT |-> s_reg.ftmr == '0)
		else $error("fault timer ran during soft-start");
	therm_trip_a: assert property (sn.over_temp &&
		s_reg.supply_on && s_reg.st != seq_pkg::ST_OFF |=>
		s_reg.st == seq_pkg::ST_FAULT && rails.ref_en)
		else $error("thermal trip not immediate");
	uvlo_off_a: assert property (!s_reg.supply_on |=>
		!rails.boost_en && !rails.opamp_en &&
		!rails.source_switch_on && !rails.drain_switch_on)
		else $error("outputs active in UVLO");

	run_c:   cover property (rails.opamp_en && rails.source_switch_on);
	tfault_c: cover property (expire);
	therm_c: cover property (sn.over_temp && rails.boost_en);
	irq_c:   cover property ($rose(irq));

endmodule : power_sequencer

// ==== seq_pkg.sv ====
package seq_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ      = 20_000_000;
	localparam int unsigned SS_TIME_US  = 14_000;   // Soft-start span
	localparam int unsigned SS_STEPS    = 128;      // DAC steps
	// Cycles per DAC step, rounded down so the ramp never overruns
	localparam int unsigned SS_STEP_CYC =
		(CLK_HZ / 1_000_000) * SS_TIME_US / SS_STEPS;
	localparam int unsigned FAULT_TIME_MS = 200;    // Fault timer
	localparam int unsigned FAULT_CYC     =
		(CLK_HZ / 1000) * FAULT_TIME_MS;

	// ------------------------------------------------------------
	// Register map (byte offsets) and reset values
	// ------------------------------------------------------------
	localparam logic [3:0] OFS_STATUS   = 4'h0;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h4;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h8;
	localparam logic [3:0] OFS_CTRL     = 4'hC;
	localparam logic [3:0] MASK_RST     = 4'h0;
	localparam logic       SW_EN_RST    = 1'h1;

	// Event bit positions in status and mask
	localparam int unsigned EV_RUN   = 0;
	localparam int unsigned EV_FAULT = 1;
	localparam int unsigned EV_THERM = 2;
	localparam int unsigned EV_UVLO  = 3;
	localparam int unsigned EV_W     = 4;

	// Status word fields
	localparam int unsigned STS_STATE = 0;  // Three bits
	localparam int unsigned STS_FAULT = 3;
	localparam int unsigned STS_SUPP  = 4;
	localparam int unsigned STS_SEL   = 5;
	localparam int unsigned STS_OK    = 6;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF   = 3'h0,
		ST_REF   = 3'h1,
		ST_SOFT  = 3'h2,
		ST_REGW  = 3'h3,
		ST_DELAY = 3'h4,
		ST_RUN   = 3'h5,
		ST_FAULT = 3'h6
	} seq_state_t;

	// Comparator and pin levels, all asynchronous to clk
	typedef struct packed {
		logic supply_above_rise;  // Input above rising UVLO level
		logic supply_above_fall;  // Input above falling UVLO level
		logic ref_above_en;       // Reference past enable level
		logic boost_ok;           // Boost past fault threshold
		logic gon_ok;             // Gate-on past fault threshold
		logic goff_ok;            // Gate-off past fault threshold
		logic cap_above;          // Delay capacitor past threshold
		logic over_temp;          // Die too hot
		logic switch_select_input;
	} sense_t;

	// Enables driven to the analog blocks
	typedef struct packed {
		logic ref_en;
		logic boost_en;
		logic gon_en;
		logic goff_en;
		logic delay_cap_pin_low;  // Delay pin pulled to ground
		logic opamp_en;           // Low means outputs high-Z
		logic source_switch_on;
		logic drain_switch_on;
	} rails_t;

endpackage : seq_pkg

// ==== level_sync.sv ====
`timescale 1ns/100ps
module level_sync #(
	parameter int unsigned W = 9
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	// ------------------------------------------------------------
	// Two-stage synchroniser
	// ------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] meta;  // Read only by the second stage
		logic [W-1:0] stab;
	} sync_state_t;

	sync_state_t st_reg;
	sync_state_t st_next;

	// Next state
	always_comb
	begin
		st_next      = st_reg;
		st_next.meta = d;
		st_next.stab = st_reg.meta;
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign q = st_reg.stab;

endmodule : level_sync

// ==== softstart_dac.sv ====
`timescale 1ns/100ps
module softstart_dac #(
	parameter bit          DOWN     = 1'b0,
	parameter int unsigned STEP_CYC = seq_pkg::SS_STEP_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       run,
	output logic      [6:0] code,
	output logic            done
);

	// ------------------------------------------------------------
	// 7-bit ramp, 128 equal steps
	// ------------------------------------------------------------
	typedef struct packed {
		logic [11:0] pre;    // Cycles within one step
		logic [7:0]  steps;  // Steps taken, 0..128
		logic [6:0]  code;
		logic        done;
	} dac_state_t;

	localparam logic [6:0] START = DOWN ? 7'h7F : 7'h00;
	localparam logic [6:0] END   = DOWN ? 7'h00 : 7'h7F;

	dac_state_t st_reg;
	dac_state_t st_next;

	// Step the code once per step interval; restart when disabled
	always_comb
	begin
		st_next = st_reg;
		if (!run)
		begin
			st_next      = '0;
			st_next.code = START;
		end
		else if (!st_reg.done)
		begin
			if (st_reg.pre == 12'(STEP_CYC - 1))
			begin
				st_next.pre   = '0;
				st_next.steps = st_reg.steps + 8'h01;
				if (st_next.steps == 8'h80)
				begin
					st_next.done = 1'b1;
					st_next.code = END;  // End point, 7F up or 00 down
				end
				else if (DOWN)
					st_next.code = st_reg.code - 7'h01;
				else
					st_next.code = st_reg.code + 7'h01;
			end
			else
				st_next.pre = st_reg.pre + 12'h001;
		end
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_reg      <= '0;
			st_reg.code <= START;
		end
		else
			st_reg <= st_next;
	end

	assign code = st_reg.code;
	assign done = st_reg.done;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	ramp_end_a: assert property (done |-> code == END)
		else $error("ramp ended away from its end code");
	ramp_dir_a: assert property (run && !done |=>
		(DOWN ? code <= $past(code) : code >= $past(code)))
		else $error("ramp moved the wrong way");

endmodule : softstart_dac

// ==== sel_driver.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Timing controller stand-in driving the select line
// ------------------------------------------------------------
module sel_driver (
	input  wire logic clk,
	input  wire logic hold,
	output logic      sel
);
	integer seed = 32'h1DDC;  // Fixed seed keeps runs repeatable
	logic   lvl  = 1'b0;      // Driven from time zero, never floats

	// Hold keeps the level still so the bench can judge the switches
	always @(posedge clk)
	begin
		if (!hold && $random(seed) % 2 == 0)
			lvl <= ~lvl;
	end

	assign sel = lvl;
endmodule : sel_driver

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
	// ------------------------------------------------------------
	// Settings and nets
	// ------------------------------------------------------------
	localparam int         SS   = 4;      // Short soft-start step
	localparam int         FC   = 50;     // Short fault timer
	localparam logic [7:0] SUP  = 8'hC0;  // Both supply comparators
	localparam logic [7:0] REFL = 8'h20;  // Reference past enable
	localparam logic [7:0] OKS  = 8'h1C;  // All outputs good
	localparam logic [7:0] CAPL = 8'h02;  // Delay capacitor past level
	localparam logic [7:0] HOT  = 8'h01;  // Die too hot
	localparam logic [7:0] ALL  = SUP | REFL | OKS | CAPL;
	logic            clk;
	logic            rst;
	logic            read;
	logic            write;
	logic            waitrequest;
	logic            irq;
	logic            sel_w;
	logic            hold;
	logic            sw_en;
	logic            bad;
	logic [7:0]      sn;
	logic [3:0]      address;
	logic [31:0]     writedata;
	logic [31:0]     readdata;
	logic [6:0]      boost_dac;
	logic [6:0]      gon_dac;
	logic [6:0]      goff_dac;
	seq_pkg::rails_t rails;
	int              err_count;
	int              num_checks;
	int              last_n;     // Cycles taken by the last change
	integer          seed = 32'h1DDC;

	// ------------------------------------------------------------
	// Design and partner
	// ------------------------------------------------------------
	power_sequencer #(.FAULT_CYCLES(FC), .SS_STEP(SS)) i_power_sequencer (
		.clk(clk), .rst(rst), .sense({sn, sel_w}), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .rails(rails),
		.boost_dac(boost_dac), .gon_dac(gon_dac), .goff_dac(goff_dac),
		.irq(irq)
	);
	sel_driver i_sel_driver (.clk(clk), .hold(hold), .sel(sel_w));

	// Free-running clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Model and helpers
	// ------------------------------------------------------------
	// Rails expected in each state; only RUN looks at the select line
	function automatic logic [7:0] exp_rails(input int st);
		case (st)
			0:       return 8'h08;
			1:       return 8'h88;
			2, 3:    return 8'hF8;
			4:       return 8'hF0;
			5:       return {6'h3D, sel_w & sw_en, ~sel_w & sw_en};
			default: return 8'h88;
		endcase
	endfunction : exp_rails

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
			err_count++;
		end
	endtask : chk

	// One Avalon transfer; the request stands until waitrequest is low
	task automatic bus(input logic [3:0] a, input logic wr,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		address <= a;
		write <= wr;
		read <= ~wr;
		writedata <= d;
		// Only the watchdog ends a wait whose answer never comes
		do
			@(posedge clk);
		while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask : wr

	task automatic rdm(input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk(q & m, e);
	endtask : rdm

	task automatic drive(input logic [7:0] v);
		@(posedge clk);
		sn <= v;
	endtask : drive

	// Wait for the model state; any other rails value on the way is stray
	task automatic go(input int st);
		logic [7:0] was;
		logic       stray;
		// Start from what stands now: a register write may have moved
		// the target before this call
		was = rails;
		stray = 1'b0;
		last_n = 0;
		while (rails !== exp_rails(st) && last_n < 2000)
		begin
			stray |= (rails !== was);
			@(posedge clk);
			last_n++;
		end
		chk(rails, exp_rails(st));
		chk(stray, 1'b0);
	endtask : go

	task automatic bring_up;
		int n;
		drive(SUP);
		go(1);
		drive(SUP | REFL);
		go(2);
		chk({boost_dac, goff_dac}, 14'h007F);
		n = 0;
		bad = 1'b0;
		while (boost_dac !== 7'h7F && n < 2000)
		begin
			bad |= gon_dac !== boost_dac || !rails[3];
			bad |= goff_dac !== 7'h7F - boost_dac;
			@(posedge clk);
			n++;
		end
		drive(SUP | REFL | OKS);
		chk(bad, 1'b0);
		chk(n >= 127 * SS - 4 && n <= 128 * SS + 4, 1'b1);
		chk(goff_dac, 7'h00);
		go(4);
		hold <= 1'b0;
		repeat (30) @(posedge clk);
		hold <= 1'b1;
		chk(rails, 8'hF0);
		drive(ALL);
		go(5);
	endtask : bring_up

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// Watchdog: whole run needs about 2200 cycles
	// ------------------------------------------------------------
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		sn = 8'h00;
		address = 4'h0;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		hold = 1'b1;
		sw_en = 1'b1;
		err_count = 0;
		num_checks = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(rails, 8'h08);
		rdm(seq_pkg::OFS_STATUS, 32'h7, 32'h0);
		rdm(seq_pkg::OFS_CTRL, 32'h1, 32'h1);
		// Unmapped address: write ignored, read zero
		wr(4'h2, $random(seed));
		rdm(4'h2, 32'hFFFFFFFF, 32'h0);
		rdm(seq_pkg::OFS_IRQ_MASK, 32'hF, 32'h0);
		repeat (40) @(posedge clk);
		chk(rails, 8'h08);
		bring_up();
		rdm(seq_pkg::OFS_STATUS, 32'h7F, {25'h0, 1'b1, sel_w, 5'h15});
		// Switches follow the select level once running
		for (int i = 0; i < 12; i++)
		begin
			hold <= 1'b0;
			@(posedge clk);
			hold <= 1'b1;
			repeat (6) @(posedge clk);
			chk(rails, exp_rails(5));
		end
		// Interrupt: sticky, masked, cleared by writing one
		rdm(seq_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
		chk(irq, 1'b0);
		wr(seq_pkg::OFS_IRQ_MASK, 32'h1);
		repeat (3) @(posedge clk);
		chk(irq, 1'b1);
		wr(seq_pkg::OFS_IRQ_STAT, 32'h1);
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		// Switch disable opens both switches
		wr(seq_pkg::OFS_CTRL, 32'h0);
		sw_en = 1'b0;
		go(5);
		wr(seq_pkg::OFS_CTRL, 32'h1);
		sw_en = 1'b1;
		go(5);
		// A fault shorter than the timer leaves the part running
		drive(ALL & ~8'h10);
		repeat (FC - 20) @(posedge clk);
		drive(ALL);
		repeat (FC) @(posedge clk);
		chk(rails, exp_rails(5));
		drive(ALL & ~8'h10);
		go(6);
		chk(last_n >= FC && last_n <= FC + 8, 1'b1);
		drive(ALL);
		repeat (100) @(posedge clk);
		chk(rails, 8'h88);
		rdm(seq_pkg::OFS_STATUS, 32'h8, 32'h8);
		drive(8'h00);
		go(0);
		rdm(seq_pkg::OFS_IRQ_STAT, 32'h8, 32'h8);
		bring_up();
		drive(ALL | HOT);
		go(6);
		chk(last_n <= 6, 1'b1);
		rdm(seq_pkg::OFS_IRQ_STAT, 32'h4, 32'h4);
		drive(8'h00);
		go(0);
		bring_up();
		drive(REFL | OKS | CAPL);
		go(0);
		report_and_stop();
	end
endmodule : tb_top
